// ===== swc_pkg.sv
// Package: register offsets, field layout and reset values of the selective-wake configuration bank
package swc_pkg;
    // 7-bit register addresses
    localparam logic [6:0] ADDR_PAYLOAD_BYTE3 = 7'h30;
    localparam logic [6:0] ADDR_PAYLOAD_BYTE2 = 7'h31;
    localparam logic [6:0] ADDR_PAYLOAD_BYTE1 = 7'h32;
    localparam logic [6:0] ADDR_PAYLOAD_BYTE0 = 7'h33;
    localparam logic [6:0] ADDR_FD_CONFIG = 7'h34;
    localparam logic [6:0] ADDR_FINE_TRIM = 7'h38;
    localparam logic [6:0] ADDR_OPTIONS = 7'h39;
    // Fields of the FD-tolerant configuration register
    localparam int FD_ERR_DIS_BIT = 5;
    localparam int FD_BYPASS_BIT = 4;
    localparam int FD_FILT_HI = 3;
    localparam int FD_FILT_LO = 1;
    localparam int FD_ENABLE_BIT = 0;
    localparam logic [7:0] FD_WRITE_MASK = 8'h3F;
    // Fields of the options register
    localparam int OPT_RX_SEL_BIT = 7;
    localparam int OPT_COARSE_HI = 4;
    localparam int OPT_COARSE_LO = 0;
    localparam logic [7:0] OPT_WRITE_MASK = 8'h9F;
    // Trim-enable key value
    localparam logic [1:0] TRIM_KEY_OPEN = 2'h3;
    // Values after power-on or soft reset
    localparam logic [7:0] PAYLOAD_RESET = 8'h00;
    localparam logic [7:0] FD_RESET = 8'h00;
    localparam logic [7:0] OPT_UPPER_RESET = 8'h00;
    // Dominant filter time per code, in ns
    localparam int FILT_STEP_NS = 50;
    localparam int FILT_LONG_NS = 3775;
    localparam logic [2:0] FILT_CODE_LONG = 3'h7;
    localparam logic [2:0] FILT_CODE_UNDEF = 3'h6;
    localparam int CLK_PERIOD_NS = 8;
    // Least times rounded up to whole cycles
    localparam int FILT_STEP_CYC = (FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_LONG_CYC = (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== swc_cfg_regs.sv
// Selective-wake configuration register bank: payload bytes, FD-tolerant control, oscillator trim
`timescale 1ns/1ns
`default_nettype none

module swc_cfg_regs (
    // Clock and asynchronous reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Register access from the serial interface
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] wr_data_in,
    // Trim key and bus silence event
    input wire logic [1:0] trim_key_in,
    input wire logic silence_timeout_in,
    // Factory trim store
    input wire logic [7:0] factory_fine_trim_in,
    input wire logic [4:0] factory_coarse_trim_in,
    input wire logic load_factory_trim_in,
    // Read side
    output logic [7:0] rd_data_out,
    output logic addr_hit_out,
    // Frame matcher and transceiver controls
    output logic [31:0] payload_pattern_out,
    output logic fd_tolerant_enable_out,
    output logic error_counter_disable_out,
    output logic analog_filter_bypass_out,
    output logic [2:0] dominant_filter_time_out,
    output logic [11:0] dominant_filter_cycles_out,
    output logic dominant_filter_undefined_out,
    // Oscillator trim and receiver select
    output logic [7:0] oscillator_trim_fine_out,
    output logic [4:0] oscillator_trim_coarse_out,
    output logic wake_receiver_select_out
);

    // Usage notes for the register interface:
    //   One access per strobe; strobes are level sampled
    //   Write lands at the taking edge
    //   Read data appears right after the edge that takes the read strobe
    //   Read data holds until the next read strobe
    //   Back-to-back accesses allowed
    //   Unmapped writes dropped, unmapped reads return zero
    //   No error response on any access
    // Trim and receiver select:
    //   Key sampled at the same edge as the write strobe
    //   Unkeyed writes dropped silently
    //   Reads still show the stored value without the key
    //   Trim flops have no reset, so factory content survives
    //   Factory load has priority over a keyed write
    //   Trim content unknown until factory load or keyed write
    //   Receiver select does reset, to the standard receiver
    // FD-tolerant register:
    //   Silence timeout clear wins over a same-cycle write
    //   Other fields of that same write still land
    //   Error-counter disable acts only with enable set
    //   Undefined filter code flagged on its own output
    //   Shortest filter time used while the code is undefined
    //   Cycle count rounded up, never shorter than asked
    //   Cycle count trails a code change by one clock
    // Limitations:
    //   No write protection beyond the trim key
    //   Oscillator trim split across two registers
    //   Coarse trim steps not monotonic; leave as loaded
    //   Address decode is combinational from the bus

    // Payload pattern storage, index 0 is the byte at the highest address
    logic [7:0] payload_q [4];

    // FD-tolerant configuration, one flop group per field
    logic err_dis_q;
    logic bypass_q;
    logic [2:0] filt_code_q;
    logic enable_q;
    logic [5:0] fd_cfg;

    // Trim content; no reset so the factory value survives every reset
    logic [7:0] fine_trim_q;
    logic [4:0] coarse_trim_q;

    // Receiver select of the options register
    logic rx_sel_q;

    // Read path
    logic [7:0] rd_data_d;
    logic [7:0] rd_data_q;
    logic [2:0] acc_index;

    // Key check and per-register write strobes
    logic key_open;
    logic wr_fd;
    logic wr_fine;
    logic wr_opt;
    logic keyed_fine;
    logic keyed_opt;

    // Filter time in clock cycles
    logic [11:0] filt_cycles_d;
    logic [11:0] filt_cycles_q;

    // Payload byte index from address, or 4 when not a payload byte
    function automatic logic [2:0] payload_index(input logic [6:0] a);
        unique case (a)
            swc_pkg::ADDR_PAYLOAD_BYTE0: payload_index = 3'h0;
            swc_pkg::ADDR_PAYLOAD_BYTE1: payload_index = 3'h1;
            swc_pkg::ADDR_PAYLOAD_BYTE2: payload_index = 3'h2;
            swc_pkg::ADDR_PAYLOAD_BYTE3: payload_index = 3'h3;
            default: payload_index = 3'h4;
        endcase
    endfunction

    // True when the address selects one of the payload bytes
    function automatic logic is_payload(input logic [6:0] a);
        is_payload = (payload_index(a) != 3'h4);
    endfunction

    // Filter code to cycles; rounding up keeps the time at least as long
    function automatic logic [11:0] filt_cycles_for(input logic [2:0] code);
        logic [31:0] ns;
        ns = 32'(swc_pkg::FILT_STEP_NS);
        unique case (code)
            swc_pkg::FILT_CODE_LONG: ns = 32'(swc_pkg::FILT_LONG_NS);
            swc_pkg::FILT_CODE_UNDEF: ns = 32'(swc_pkg::FILT_STEP_NS);
            default: ns = (32'(code) + 32'h1) * 32'(swc_pkg::FILT_STEP_NS);
        endcase
        filt_cycles_for = 12'((ns + 32'(swc_pkg::CLK_PERIOD_NS) - 32'h1) / 32'(swc_pkg::CLK_PERIOD_NS));
    endfunction

    // The key is checked at the very edge that takes the write
    assign key_open = (trim_key_in == swc_pkg::TRIM_KEY_OPEN);

    // Write strobes per register; trim strobes also need the key
    assign wr_fd = wr_en_in && (addr_in == swc_pkg::ADDR_FD_CONFIG);
    assign wr_fine = wr_en_in && (addr_in == swc_pkg::ADDR_FINE_TRIM);
    assign wr_opt = wr_en_in && (addr_in == swc_pkg::ADDR_OPTIONS);
    assign keyed_fine = wr_fine && key_open;
    assign keyed_opt = wr_opt && key_open;

    // Index into payload storage for reads; only low bits used
    assign acc_index = payload_index(addr_in);

    // Payload pattern bytes, one per data position
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_payload
            always_ff @(posedge clk_sys_in or posedge reset_in) begin
                if (reset_in) begin
                    payload_q[gi] <= swc_pkg::PAYLOAD_RESET;
                end else if (wr_en_in && payload_index(addr_in) == 3'(gi)) begin
                    payload_q[gi] <= wr_data_in;
                end
            end
            assign payload_pattern_out[8*gi +: 8] = payload_q[gi];
        end
    endgenerate

    // Error-counter disable; hardware clear beats a software write
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            err_dis_q <= swc_pkg::FD_RESET[swc_pkg::FD_ERR_DIS_BIT];
        end else if (silence_timeout_in) begin
            err_dis_q <= 1'b0;
        end else if (wr_fd) begin
            err_dis_q <= wr_data_in[swc_pkg::FD_ERR_DIS_BIT];
        end
    end

    // Analog filter bypass
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            bypass_q <= swc_pkg::FD_RESET[swc_pkg::FD_BYPASS_BIT];
        end else if (wr_fd) begin
            bypass_q <= wr_data_in[swc_pkg::FD_BYPASS_BIT];
        end
    end

    // Dominant filter time code
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            filt_code_q <= swc_pkg::FD_RESET[swc_pkg::FD_FILT_HI:swc_pkg::FD_FILT_LO];
        end else if (wr_fd) begin
            filt_code_q <= wr_data_in[swc_pkg::FD_FILT_HI:swc_pkg::FD_FILT_LO];
        end
    end

    // FD-tolerant mode enable
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            enable_q <= swc_pkg::FD_RESET[swc_pkg::FD_ENABLE_BIT];
        end else if (wr_fd) begin
            enable_q <= wr_data_in[swc_pkg::FD_ENABLE_BIT];
        end
    end

    // Stored FD configuration as seen by reads
    assign fd_cfg = {err_dis_q, bypass_q, filt_code_q, enable_q};

    // Fine trim: not reset, loaded from factory store, keyed writes only
    always_ff @(posedge clk_sys_in) begin
        if (load_factory_trim_in) begin
            fine_trim_q <= factory_fine_trim_in;
        end else if (keyed_fine) begin
            fine_trim_q <= wr_data_in;
        end
    end

    // Coarse trim keeps factory content too; reset does not touch it
    always_ff @(posedge clk_sys_in) begin
        if (load_factory_trim_in) begin
            coarse_trim_q <= factory_coarse_trim_in;
        end else if (keyed_opt) begin
            coarse_trim_q <= wr_data_in[swc_pkg::OPT_COARSE_HI:swc_pkg::OPT_COARSE_LO];
        end
    end

    // Receiver select resets to standard receiver
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rx_sel_q <= swc_pkg::OPT_UPPER_RESET[swc_pkg::OPT_RX_SEL_BIT];
        end else if (keyed_opt) begin
            rx_sel_q <= wr_data_in[swc_pkg::OPT_RX_SEL_BIT];
        end
    end

    // Read select; reserved bits forced to zero, unmapped reads zero
    always_comb begin
        rd_data_d = 8'h00;
        if (is_payload(addr_in)) begin
            rd_data_d = payload_q[acc_index[1:0]];
        end else if (addr_in == swc_pkg::ADDR_FD_CONFIG) begin
            rd_data_d = {2'h0, fd_cfg} & swc_pkg::FD_WRITE_MASK;
        end else if (addr_in == swc_pkg::ADDR_FINE_TRIM) begin
            rd_data_d = fine_trim_q;
        end else if (addr_in == swc_pkg::ADDR_OPTIONS) begin
            rd_data_d = {rx_sel_q, 2'h0, coarse_trim_q} & swc_pkg::OPT_WRITE_MASK;
        end else begin
            rd_data_d = 8'h00;
        end
    end

    // Read data register; holds until the next read strobe
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_q <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_q <= rd_data_d;
        end
    end

    // Read data and address decode to the serial interface
    assign rd_data_out = rd_data_q;
    assign addr_hit_out = is_payload(addr_in) || (addr_in == swc_pkg::ADDR_FD_CONFIG)
        || (addr_in == swc_pkg::ADDR_FINE_TRIM) || (addr_in == swc_pkg::ADDR_OPTIONS);

    // Filter time as cycles; undefined code falls back to the shortest
    always_comb begin
        filt_cycles_d = filt_cycles_for(filt_code_q);
    end

    // Registered cycle count keeps the divider off the output path
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            filt_cycles_q <= 12'h000;
        end else begin
            filt_cycles_q <= filt_cycles_d;
        end
    end

    // FD-tolerant controls to the transceiver and frame detector
    assign fd_tolerant_enable_out = enable_q;
    assign error_counter_disable_out = err_dis_q & enable_q;
    assign analog_filter_bypass_out = bypass_q;

    // Filter settings; the cycle count trails the code by one clock
    assign dominant_filter_time_out = filt_code_q;
    assign dominant_filter_cycles_out = filt_cycles_q;
    assign dominant_filter_undefined_out = (filt_code_q == swc_pkg::FILT_CODE_UNDEF);

    // Oscillator trim and receiver select
    assign oscillator_trim_fine_out = fine_trim_q;
    assign oscillator_trim_coarse_out = coarse_trim_q;
    assign wake_receiver_select_out = rx_sel_q;

endmodule

`default_nettype wire

// ===== swc_checker.sv
// Checker: port-level assertions for the selective-wake configuration bank
`timescale 1ns/1ns
`default_nettype none
module swc_checker (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [1:0] trim_key_in,
    input wire logic silence_timeout_in,
    input wire logic load_factory_trim_in,
    input wire logic [7:0] rd_data_out,
    input wire logic fd_tolerant_enable_out,
    input wire logic error_counter_disable_out,
    input wire logic analog_filter_bypass_out,
    input wire logic [2:0] dominant_filter_time_out,
    input wire logic [11:0] dominant_filter_cycles_out,
    input wire logic dominant_filter_undefined_out,
    input wire logic [7:0] oscillator_trim_fine_out,
    input wire logic [4:0] oscillator_trim_coarse_out,
    input wire logic wake_receiver_select_out
);
    localparam logic [6:0] FD = swc_pkg::ADDR_FD_CONFIG;
    localparam logic [6:0] OPT = swc_pkg::ADDR_OPTIONS;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    // Gated and cleared behaviour of the error-counter disable
    chk_err_dis_gated: assert property (error_counter_disable_out |-> fd_tolerant_enable_out)
        else $error("error counter disabled without enable");
    chk_silence_clears: assert property (silence_timeout_in |=> !error_counter_disable_out)
        else $error("silence timeout did not clear disable");
    chk_fd_write: assert property (wr_en_in && addr_in == FD |=>
        {analog_filter_bypass_out, dominant_filter_time_out, fd_tolerant_enable_out} == $past(wr_data_in[4:0])
        && error_counter_disable_out == ($past(wr_data_in[5] & wr_data_in[0]) && !$past(silence_timeout_in)))
        else $error("FD config write not reflected");
    // Filter code decoding; the cycle count is registered one cycle late
    chk_undef_flag: assert property (
        dominant_filter_undefined_out == (dominant_filter_time_out == 3'h6))
        else $error("undefined filter flag wrong");
    chk_long_filter: assert property (
        $past(dominant_filter_time_out) == 3'h7 |-> dominant_filter_cycles_out == 12'h1D8)
        else $error("long filter time wrong");
    // Trim and receiver select stay put without the key
    chk_fine_locked: assert property (
        wr_en_in && addr_in == swc_pkg::ADDR_FINE_TRIM && trim_key_in != 2'h3 && !load_factory_trim_in
        |=> $stable(oscillator_trim_fine_out)) else $error("fine trim written without key");
    chk_opt_locked: assert property (
        wr_en_in && addr_in == OPT && trim_key_in != 2'h3 && !load_factory_trim_in
        |=> $stable({wake_receiver_select_out, oscillator_trim_coarse_out})) else $error("options written without key");
    chk_reserved_zero: assert property (rd_en_in |=> ($past(addr_in) != FD || rd_data_out[7:6] == 2'h0)
        && ($past(addr_in) != OPT || rd_data_out[6:5] == 2'h0)) else $error("reserved bits read nonzero");
    // Main scenarios reached
    cov_fd_write: cover property (wr_en_in && addr_in == FD);
    cov_silence: cover property (silence_timeout_in && error_counter_disable_out);
    cov_keyed_opt: cover property (wr_en_in && addr_in == OPT && trim_key_in == 2'h3);
endmodule
bind swc_cfg_regs swc_checker chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .trim_key_in(trim_key_in),
    .silence_timeout_in(silence_timeout_in), .load_factory_trim_in(load_factory_trim_in),
    .rd_data_out(rd_data_out), .fd_tolerant_enable_out(fd_tolerant_enable_out),
    .error_counter_disable_out(error_counter_disable_out), .analog_filter_bypass_out(analog_filter_bypass_out),
    .dominant_filter_time_out(dominant_filter_time_out), .dominant_filter_cycles_out(dominant_filter_cycles_out),
    .dominant_filter_undefined_out(dominant_filter_undefined_out), .oscillator_trim_fine_out(oscillator_trim_fine_out),
    .oscillator_trim_coarse_out(oscillator_trim_coarse_out), .wake_receiver_select_out(wake_receiver_select_out));
`default_nettype wire

// ===== swc_host_model.sv
// Host model: issues register reads and writes as the serial master would
`timescale 1ns/1ns
`default_nettype none
module swc_host_model (
    input wire logic clk_sys_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [6:0] addr_out,
    output logic [7:0] wr_data_out
);
    // Idle bus at start
    initial {wr_en_out, rd_en_out, addr_out, wr_data_out} = 17'h0;
    // Request set after an edge, dropped after the taking edge
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys_in) #1;
        {wr_en_out, rd_en_out, addr_out, wr_data_out} = {w, ~w, a, d};
        @(posedge clk_sys_in) #1;
        {wr_en_out, rd_en_out, addr_out, wr_data_out} = {2'h0, ~a, ~d}; // Inverted so no stale value lingers
    endtask
    // Receiver change writes the coarse trim back as read
    task automatic set_rx(input logic sel, input logic [7:0] cur);
        xfer(1'b1, swc_pkg::ADDR_OPTIONS, {sel, 2'h0, cur[4:0]});
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Testbench: directed scenarios for the selective-wake configuration bank
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_sys_in = 1'b0, reset_in = 1'b1, silence = 1'b0, load = 1'b0, wr_en, rd_en, hit, fd_en, err_dis;
    logic byp, undef, rxsel;
    logic [1:0] key = 2'h0;
    logic [6:0] addr;
    logic [7:0] wdata, rd_data, fine;
    logic [31:0] payload;
    logic [2:0] ftime;
    logic [11:0] fcyc;
    logic [4:0] coarse;
    int fails = 0, compares = 0;
    localparam logic [6:0] FD = swc_pkg::ADDR_FD_CONFIG;
    swc_host_model host (.clk_sys_in(clk_sys_in), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
        .wr_data_out(wdata));
    swc_cfg_regs dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .addr_in(addr), .wr_data_in(wdata), .trim_key_in(key), .silence_timeout_in(silence),
        .factory_fine_trim_in(8'h5A), .factory_coarse_trim_in(5'h0C), .load_factory_trim_in(load),
        .rd_data_out(rd_data), .addr_hit_out(hit), .payload_pattern_out(payload), .fd_tolerant_enable_out(fd_en),
        .error_counter_disable_out(err_dis), .analog_filter_bypass_out(byp), .dominant_filter_time_out(ftime),
        .dominant_filter_cycles_out(fcyc), .dominant_filter_undefined_out(undef),
        .oscillator_trim_fine_out(fine), .oscillator_trim_coarse_out(coarse), .wake_receiver_select_out(rxsel));
    // 125 MHz clock
    initial forever #4 clk_sys_in = ~clk_sys_in;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Read one register and compare the returned byte
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        host.xfer(1'b0, a, 8'h00);
        check(rd_data, exp);
    endtask
    task automatic t_reset;
        for (logic [6:0] a = 7'h30; a <= 7'h34; a++) rd(a, 8'h00);
    endtask
    task automatic t_payload;
        for (logic [6:0] a = 7'h30; a <= 7'h33; a++) host.xfer(1'b1, a, {1'h1, a});
        check(payload, 32'hB0B1B2B3);
        rd(7'h31, 8'hB1);
    endtask
    task automatic t_fd;
        host.xfer(1'b1, FD, 8'hFF);
        rd(FD, 8'h3F);
        check({err_dis, byp, ftime, fd_en}, 6'h3F);
        host.xfer(1'b1, FD, 8'h20);
        check({err_dis, fd_en}, 2'h0);
        // Codes 0 through 5; cycles land one edge after the write
        for (logic [2:0] c = 3'h0; c < 3'h6; c++) begin
            host.xfer(1'b1, FD, {4'h0, c, 1'b1});
            @(posedge clk_sys_in) #1;
            check(fcyc, (50 * (c + 1) + 7) / 8);
        end
        host.xfer(1'b1, FD, 8'h0C);
        check(undef, 1'b1);
        host.xfer(1'b1, FD, 8'h21);
        @(posedge clk_sys_in) #1 silence = 1'b1;
        @(posedge clk_sys_in) #1 silence = 1'b0;
        rd(FD, 8'h01);
    endtask
    task automatic t_trim;
        @(posedge clk_sys_in) #1 load = 1'b1;
        @(posedge clk_sys_in) #1 load = 1'b0;
        host.xfer(1'b1, swc_pkg::ADDR_FINE_TRIM, 8'hFF);
        host.xfer(1'b1, swc_pkg::ADDR_OPTIONS, 8'hFF);
        rd(swc_pkg::ADDR_FINE_TRIM, 8'h5A);
        rd(swc_pkg::ADDR_OPTIONS, 8'h0C);
        key = 2'h3;
        host.xfer(1'b1, swc_pkg::ADDR_FINE_TRIM, 8'h53);
        rd(swc_pkg::ADDR_FINE_TRIM, 8'h53);
        host.set_rx(1'b1, 8'h0C);
        rd(swc_pkg::ADDR_OPTIONS, 8'h8C);
        check({rxsel, coarse, fine}, {1'b1, 5'h0C, 8'h53});
        // Host leaves the inverted address behind: 0x4A unmapped, 0x33 mapped
        rd(7'h35, 8'h00);
        #1 check(hit, 1'b0);
        rd(7'h4C, 8'h00);
        #1 check(hit, 1'b1);
        // Second reset: trim kept, FD bank cleared
        reset_in = 1'b1;
        @(posedge clk_sys_in) #1 reset_in = 1'b0;
        rd(swc_pkg::ADDR_FINE_TRIM, 8'h53);
        rd(FD, 8'h00);
    endtask
    task automatic stop_test;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected run of under a hundred cycles
    initial begin
        #200000;
        fails++;
        stop_test;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys_in);
        #1 reset_in = 1'b0;
        t_reset;
        t_payload;
        t_fd;
        t_trim;
        stop_test;
    end
endmodule
`default_nettype wire
